// >>> core/color_sense_pkg.sv
// constants, field layouts and carrier types of the color sensor control core
// assumes a single 20 MHz core clock and a 16-bit register access port
package color_sense_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_HIGH_THRESHOLD = 8'h09;
    localparam logic [7:0] REG_MEAS_CONFIG = 8'h0A;

    // ------------------------------------------------------------
    // measurement_config field positions
    // ------------------------------------------------------------
    localparam int CFG_WAKE_BIT = 15;
    localparam int CFG_ZERO_BIT = 14;
    localparam int CFG_RANGE_LSB = 10;
    localparam int CFG_CTIME_LSB = 6;
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_LATCH_BIT = 3;
    localparam int CFG_POL_BIT = 2;
    localparam int CFG_FAULT_LSB = 0;

    // ------------------------------------------------------------
    // high_threshold field positions and resets
    // ------------------------------------------------------------
    localparam int THR_EXP_LSB = 12;
    localparam int THR_MANT_LSB = 0;
    localparam logic [3:0] THR_H_EXP_RST = 4'hB;
    localparam logic [11:0] THR_H_MANT_RST = 12'hFFF;

    // ------------------------------------------------------------
    // measurement_config values and resets
    // ------------------------------------------------------------
    localparam logic [15:0] CFG_RESET = 16'h3208;
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    localparam logic [3:0] RANGE_MAX_FIXED = 4'h6;
    localparam logic [3:0] RANGE_MIN_FIXED = 4'h0;
    localparam logic [3:0] CTIME_MAX = 4'hB;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h0;
    localparam logic [1:0] MODE_FORCED_AUTO = 2'h1;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h2;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h3;
    localparam logic [11:0] AUTO_DOWN_LIMIT = 12'h400;
    localparam logic [1:0] LAST_CHANNEL = 2'h3;

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int TIMER_W = 24;

    function automatic int unsigned us_to_cycles(input int unsigned time_us);
        us_to_cycles = (time_us * 1000) / CLK_PERIOD_NS;
    endfunction : us_to_cycles

    localparam int unsigned CONV_CYCLES_DEF [0:11] = '{
        us_to_cycles(600), us_to_cycles(1000), us_to_cycles(1800), us_to_cycles(3400),
        us_to_cycles(6500), us_to_cycles(12700), us_to_cycles(25000), us_to_cycles(50000),
        us_to_cycles(100000), us_to_cycles(200000), us_to_cycles(400000),
        us_to_cycles(800000)
    };

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } threshold_s;

    typedef struct packed {
        logic fast_standby_exit;
        logic [3:0] range;
        logic [3:0] conv_time;
        logic [1:0] mode;
        logic latch;
        logic alert_pin_level;
        logic [1:0] fault_count;
    } meas_config_s;

    typedef struct packed {
        logic overload;
        logic [11:0] mantissa;
    } adc_sample_s;

    typedef struct packed {
        logic [1:0] channel;
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } result_s;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_NEXT
    } seq_state_e;

endpackage : color_sense_pkg

// >>> core/conv_timer.sv
// per-channel conversion interval counter
// assumes load is not raised while a count is running
module conv_timer #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // control
    input wire logic load_in,
    input wire logic [WIDTH-1:0] cycles_in,
    // status
    output logic done_out
);
    logic [WIDTH-1:0] remaining;
    logic running;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            remaining <= '0;
            running <= 1'b0;
        end
        else if (load_in)
        begin
            remaining <= cycles_in;
            running <= 1'b1;
        end
        else if (running)
        begin
            remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
            running <= (remaining > {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            done_out <= 1'b0;
        else
            done_out <= running && (remaining <= {{(WIDTH-1){1'b0}}, 1'b1}) && !load_in;
    end

endmodule : conv_timer

// >>> core/threshold_filter.sv
// window comparator with consecutive-fault filter for one monitored channel
// assumes samples arrive as one-cycle strobes with exponent already attached
module threshold_filter
    import color_sense_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // sample stream
    input wire logic sample_valid_in,
    input wire result_s sample_in,
    // settings
    input wire logic [1:0] compare_channel_sel_in,
    input wire threshold_s high_thr_in,
    input wire threshold_s low_thr_in,
    input wire logic [1:0] fault_count_in,
    input wire logic latch_in,
    input wire logic flag_clear_in,
    // flags
    output logic flag_h_out,
    output logic flag_l_out
);
    logic [26:0] level;
    logic [26:0] high_level;
    logic [26:0] low_level;
    logic [3:0] need;
    logic [3:0] count_h;
    logic [3:0] count_l;
    logic watched;
    logic over;
    logic under;
    logic trip_h;
    logic trip_l;

    // compare in linear units so unnormalised mantissas order correctly
    assign level = {15'h0000, sample_in.mantissa} << sample_in.exponent;
    assign high_level = {15'h0000, high_thr_in.mantissa} << high_thr_in.exponent;
    assign low_level = {15'h0000, low_thr_in.mantissa} << low_thr_in.exponent;
    assign need = 4'h1 << fault_count_in; // [RL10]
    assign watched = sample_valid_in && (sample_in.channel == compare_channel_sel_in); // [RL12]
    assign over = level > high_level; // [RL13]
    assign under = level < low_level;
    assign trip_h = watched && over && ((count_h + 4'h1) >= need);
    assign trip_l = watched && under && ((count_l + 4'h1) >= need);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            count_h <= 4'h0;
        else if (watched)
            count_h <= over ? ((count_h >= need) ? count_h : count_h + 4'h1) : 4'h0; // [RL13]
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            count_l <= 4'h0;
        else if (watched)
            count_l <= under ? ((count_l >= need) ? count_l : count_l + 4'h1) : 4'h0;
    end

    // held mode keeps a flag until cleared; a new trip beats the clear
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            flag_h_out <= 1'b0;
        else if (trip_h)
            flag_h_out <= 1'b1; // [RL10]
        else if (latch_in ? flag_clear_in : (watched && !over))
            flag_h_out <= 1'b0; // [RL8]
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            flag_l_out <= 1'b0;
        else if (trip_l)
            flag_l_out <= 1'b1; // [RL10]
        else if (latch_in ? flag_clear_in : (watched && !under))
            flag_l_out <= 1'b0; // [RL8]
    end

endmodule : threshold_filter

// >>> core/color_sense_ctrl.sv
// measurement control and high threshold registers of the color sensor core,
// with the conversion sequencer, range selection and alert pin driver
// assumes a register port already decoded from the serial bus, one access per cycle
//
// Functional notes
// [RL1] high threshold: exponent bits 15-12, mantissa 11-0, reset B and FFF
// [RL2] fast standby exit keeps part powered in one-shot standby only
// [RL3] host always writes zero to configuration bit 14
// [RL4] range field 13-10: codes 0-6 fixed ranges, 12 auto, reset auto
// [RL5] fixed range code equals the exponent of results
// [RL6] conversion time field 9-6: codes 0-11 from 600 us to 800 ms, reset 8
// [RL7] mode field 5-4: power-down, forced auto one-shot, one-shot, continuous
// [RL8] bit 3 picks held or non-held threshold reporting, reset 1
// [RL9] bit 2 sets alert pin level: 0 active low, 1 active high
// [RL10] fault field 1-0 needs 1, 2, 4 or 8 consecutive faults
// [RL11] configuration register at 0xA resets to 0x3208
// [RL12] two-bit select picks which channel the threshold logic watches
// [RL13] fault when selected result exceeds high threshold; non-fault clears count
module color_sense_ctrl
    import color_sense_pkg::*;
#(
    parameter int unsigned CONV_CYCLES [0:11] = CONV_CYCLES_DEF
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // settings owned by neighbouring registers
    input wire logic [1:0] compare_channel_sel_in,
    input color_sense_pkg::threshold_s low_thr_in,
    input wire logic flag_clear_in,
    // analog front end
    input color_sense_pkg::adc_sample_s adc_sample_in,
    output logic [1:0] adc_channel_out,
    output logic [3:0] range_out,
    output logic core_power_out,
    output logic keep_alive_out,
    // results and flags
    output color_sense_pkg::result_s result_out,
    output logic result_valid_out,
    output logic flag_h_out,
    output logic flag_l_out,
    // alert pin
    output logic alert_out
);
    import color_sense_pkg::*;

    // ------
    // register state
    // ------
    threshold_s high_thr;
    meas_config_s cfg;
    logic wr_thr;
    logic wr_cfg;
    logic [1:0] wr_mode;

    assign wr_thr = reg_write_in && (reg_addr_in == REG_HIGH_THRESHOLD);
    assign wr_cfg = reg_write_in && (reg_addr_in == REG_MEAS_CONFIG);
    assign wr_mode = reg_wdata_in[CFG_MODE_LSB +: 2];

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            high_thr.exponent <= THR_H_EXP_RST; // [RL1]
            high_thr.mantissa <= THR_H_MANT_RST; // [RL1]
        end
        else if (wr_thr)
        begin
            high_thr.exponent <= reg_wdata_in[THR_EXP_LSB +: 4]; // [RL1]
            high_thr.mantissa <= reg_wdata_in[THR_MANT_LSB +: 12]; // [RL1]
        end
    end

    // ------
    // sequencer signals
    // ------
    seq_state_e state;
    seq_state_e next_state;
    logic [1:0] channel;
    logic timer_load;
    logic timer_done;
    logic [TIMER_W-1:0] conv_len;
    logic [3:0] ctime_code;
    logic burst_end;
    logic one_shot_end;
    logic auto_active;
    logic [3:0] auto_range;
    logic [3:0] active_range;
    logic forced_run;
    logic last_was_one_shot;

    assign burst_end = (state == SEQ_CONVERT) && timer_done && (channel == LAST_CHANNEL);
    assign one_shot_end = burst_end && (cfg.mode != MODE_CONTINUOUS);

    // a finished one-shot drops the mode to power-down; a write in that cycle wins
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            cfg <= {CFG_RESET[CFG_WAKE_BIT], CFG_RESET[13:0]}; // [RL11]
        else if (wr_cfg)
        begin
            cfg.fast_standby_exit <= reg_wdata_in[CFG_WAKE_BIT]; // [RL2]
            cfg.range <= reg_wdata_in[CFG_RANGE_LSB +: 4]; // [RL4]
            cfg.conv_time <= reg_wdata_in[CFG_CTIME_LSB +: 4]; // [RL6]
            cfg.mode <= wr_mode; // [RL7]
            cfg.latch <= reg_wdata_in[CFG_LATCH_BIT]; // [RL8]
            cfg.alert_pin_level <= reg_wdata_in[CFG_POL_BIT]; // [RL9]
            cfg.fault_count <= reg_wdata_in[CFG_FAULT_LSB +: 2]; // [RL10]
        end
        else if (one_shot_end)
            cfg.mode <= MODE_POWER_DOWN; // [RL7]
    end

    // ------
    // register read-back
    // ------
    // bit 14 is write-only and always reads zero; host keeps it zero [RL3]
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            reg_rdata_out <= 16'h0000;
        else if (reg_read_in)
        begin
            case (reg_addr_in)
                REG_HIGH_THRESHOLD: reg_rdata_out <= high_thr; // [RL1]
                REG_MEAS_CONFIG: reg_rdata_out <= {cfg.fast_standby_exit, 1'b0, cfg.range,
                    cfg.conv_time, cfg.mode, cfg.latch, cfg.alert_pin_level,
                    cfg.fault_count}; // [RL11]
                default: reg_rdata_out <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            reg_rvalid_out <= 1'b0;
        else
            reg_rvalid_out <= reg_read_in;
    end

    // ------
    // conversion sequencer
    // ------
    // unused time codes fall back to the longest interval
    assign ctime_code = (cfg.conv_time > CTIME_MAX) ? CTIME_MAX : cfg.conv_time;
    assign conv_len = TIMER_W'(CONV_CYCLES[ctime_code]); // [RL6]
    assign timer_load = (next_state == SEQ_CONVERT) && (state != SEQ_CONVERT);

    always_comb
    begin
        next_state = state;
        case (state)
            SEQ_IDLE:
                if (cfg.mode != MODE_POWER_DOWN)
                    next_state = SEQ_CONVERT; // [RL7]
            SEQ_CONVERT:
                if (timer_done)
                    next_state = burst_end ? SEQ_IDLE : SEQ_NEXT;
            SEQ_NEXT:
                next_state = (cfg.mode == MODE_POWER_DOWN) ? SEQ_IDLE : SEQ_CONVERT;
            default:
                next_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            state <= SEQ_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            channel <= 2'h0;
        else if (state == SEQ_CONVERT && timer_done)
            channel <= channel + 2'h1;
        else if (state == SEQ_IDLE)
            channel <= 2'h0;
    end

    conv_timer #(
        .WIDTH(TIMER_W)
    ) u_conv_timer (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .load_in(timer_load),
        .cycles_in(conv_len),
        .done_out(timer_done)
    );

    // ------
    // range selection
    // ------
    assign auto_active = (cfg.range == RANGE_AUTO) || forced_run; // [RL4]
    assign active_range = auto_active ? auto_range : cfg.range;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            forced_run <= 1'b0;
        else if (state == SEQ_IDLE)
            forced_run <= (cfg.mode == MODE_FORCED_AUTO); // [RL7]
    end

    // forced runs restart the search from the widest range
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            auto_range <= RANGE_MAX_FIXED;
        else if (state == SEQ_IDLE && cfg.mode == MODE_FORCED_AUTO)
            auto_range <= RANGE_MAX_FIXED;
        else if (state == SEQ_CONVERT && timer_done && auto_active)
        begin
            if (adc_sample_in.overload && auto_range < RANGE_MAX_FIXED)
                auto_range <= auto_range + 4'h1;
            else if (!adc_sample_in.overload && adc_sample_in.mantissa < AUTO_DOWN_LIMIT
                     && auto_range > RANGE_MIN_FIXED)
                auto_range <= auto_range - 4'h1;
        end
    end

    // ------
    // results
    // ------
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            result_out <= '0;
            result_valid_out <= 1'b0;
        end
        else
        begin
            result_valid_out <= (state == SEQ_CONVERT) && timer_done;
            if (state == SEQ_CONVERT && timer_done)
            begin
                result_out.channel <= channel;
                result_out.exponent <= active_range; // [RL5]
                result_out.mantissa <= adc_sample_in.mantissa;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            adc_channel_out <= 2'h0;
            range_out <= RANGE_MAX_FIXED;
        end
        else
        begin
            adc_channel_out <= channel;
            range_out <= (active_range > RANGE_MAX_FIXED) ? RANGE_MAX_FIXED : active_range;
        end
    end

    // ------
    // power control
    // ------
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            last_was_one_shot <= 1'b0;
        else if (cfg.mode == MODE_CONTINUOUS || cfg.mode == MODE_POWER_DOWN && !one_shot_end
                 && state == SEQ_IDLE && wr_cfg)
            last_was_one_shot <= 1'b0;
        else if (cfg.mode == MODE_ONE_SHOT || cfg.mode == MODE_FORCED_AUTO)
            last_was_one_shot <= 1'b1;
    end

    // partial power trades standby current for a faster next one-shot
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            core_power_out <= 1'b0;
            keep_alive_out <= 1'b0;
        end
        else
        begin
            core_power_out <= (next_state != SEQ_IDLE);
            keep_alive_out <= (next_state != SEQ_IDLE)
                || (cfg.fast_standby_exit && last_was_one_shot); // [RL2]
        end
    end

    // ------
    // threshold detection and alert pin
    // ------
    logic flag_h;
    logic flag_l;

    threshold_filter u_threshold_filter (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .sample_valid_in(result_valid_out),
        .sample_in(result_out),
        .compare_channel_sel_in(compare_channel_sel_in),
        .high_thr_in(high_thr),
        .low_thr_in(low_thr_in),
        .fault_count_in(cfg.fault_count),
        .latch_in(cfg.latch),
        .flag_clear_in(flag_clear_in),
        .flag_h_out(flag_h),
        .flag_l_out(flag_l)
    );

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            flag_h_out <= 1'b0;
            flag_l_out <= 1'b0;
            alert_out <= 1'b1;
        end
        else
        begin
            flag_h_out <= flag_h;
            flag_l_out <= flag_l;
            alert_out <= cfg.alert_pin_level ? (flag_h | flag_l) : ~(flag_h | flag_l); // [RL9]
        end
    end

endmodule : color_sense_ctrl

// >>> bench/color_sense_ctrl_props.sv
// assertions on the ports of the color sensor control core
// assumes binding to color_sense_ctrl, one clock domain
module color_sense_ctrl_props
    import color_sense_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // watched outputs
    input wire logic [3:0] range_out,
    input wire logic core_power_out,
    input wire logic keep_alive_out,
    input wire result_s result_out,
    input wire logic result_valid_out,
    input wire logic flag_h_out,
    input wire logic alert_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic pol;

    // shadow of the polarity bit, so the pin level can be predicted
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            pol <= 1'b0;
        else if (reg_write_in && reg_addr_in == REG_MEAS_CONFIG)
            pol <= reg_wdata_in[CFG_POL_BIT];
    end

    sequence s_wr_rd(a);
        reg_write_in && reg_addr_in == a ##1 !reg_write_in
            ##1 reg_read_in && !reg_write_in && reg_addr_in == a;
    endsequence

    property p_rvalid;
        reg_rvalid_out == $past(reg_read_in);
    endproperty
    property p_thr;
        s_wr_rd(REG_HIGH_THRESHOLD) |=> reg_rdata_out == $past(reg_wdata_in, 3);
    endproperty
    // mode bits masked: a one-shot may clear them on its own
    property p_cfg;
        s_wr_rd(REG_MEAS_CONFIG) |=> !reg_rdata_out[14] &&
            (reg_rdata_out & 16'hBFCF) == ($past(reg_wdata_in, 3) & 16'hBFCF);
    endproperty
    property p_range;
        range_out <= RANGE_MAX_FIXED;
    endproperty
    property p_exp;
        result_valid_out |-> result_out.exponent <= RANGE_MAX_FIXED;
    endproperty
    property p_keep;
        core_power_out |-> keep_alive_out;
    endproperty
    property p_pulse;
        result_valid_out |=> !result_valid_out;
    endproperty
    property p_flag;
        $rose(flag_h_out) |-> $past(result_valid_out, 2);
    endproperty
    property p_alert;
        $stable(pol) && pol == $past(pol, 2) |-> alert_out == (flag_h_out ~^ pol);
    endproperty

    a_rvalid: assert property (p_rvalid) else $error("read answer not one cycle later");
    a_thr: assert property (p_thr) else $error("high threshold readback wrong");
    a_cfg: assert property (p_cfg) else $error("config readback wrong");
    a_range: assert property (p_range) else $error("range pin beyond fixed codes");
    a_exp: assert property (p_exp) else $error("result exponent out of range");
    a_keep: assert property (p_keep) else $error("keep alive low while converting");
    a_pulse: assert property (p_pulse) else $error("result valid longer than a cycle");
    a_flag: assert property (p_flag) else $error("high flag rose without a result");
    a_alert: assert property (p_alert) else $error("alert level wrong");
endmodule : color_sense_ctrl_props

bind color_sense_ctrl color_sense_ctrl_props u_color_sense_ctrl_props (
    .core_clk_in, .reset_in, .reg_addr_in, .reg_write_in, .reg_wdata_in, .reg_read_in,
    .reg_rdata_out, .reg_rvalid_out, .range_out, .core_power_out, .keep_alive_out,
    .result_out, .result_valid_out, .flag_h_out, .alert_out
);

// >>> bench/reg_host.sv
// host model driving the register port of the control core
// assumes one access at a time, launched 1 ns after the rising edge
module reg_host
(
    // clock
    input wire logic core_clk_in,
    // register port
    output logic [7:0] reg_addr_out,
    output logic reg_write_out,
    output logic [15:0] reg_wdata_out,
    output logic reg_read_out,
    input wire logic [15:0] reg_rdata_in,
    input wire logic reg_rvalid_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        reg_addr_out = 8'h00;
        reg_write_out = 1'b0;
        reg_wdata_out = 16'h0000;
        reg_read_out = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        #1;
        reg_addr_out = a;
        reg_wdata_out = d & ((a == 8'h0A) ? 16'hBFFF : 16'hFFFF);
        reg_write_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_write_out = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk_in);
        #1;
        reg_addr_out = a;
        reg_read_out = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_read_out = 1'b0;
        d = reg_rvalid_in ? reg_rdata_in : 16'hXXXX;
    endtask : rd
endmodule : reg_host

// >>> bench/color_sense_ctrl_bench.sv
// self-checking bench of the color sensor control core
// assumes short conversion counts so a full sequence takes tens of cycles
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module color_sense_ctrl_bench;
    import color_sense_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_in, reset_in, reg_write_in, reg_read_in, reg_rvalid_out, flag_clear_in;
    logic [7:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out;
    logic [1:0] compare_channel_sel_in;
    logic [3:0] range_out;
    logic core_power_out, keep_alive_out, result_valid_out, flag_h_out, alert_out;
    threshold_s low_thr_in;
    adc_sample_s adc_sample_in;
    result_s result_out;
    int miscompares = 0;
    int checks_done = 0;
    int g0, g1;

    color_sense_ctrl #(
        .CONV_CYCLES('{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15})
    ) u_color_sense_ctrl (.core_clk_in, .reset_in, .reg_addr_in, .reg_write_in, .reg_wdata_in,
        .reg_read_in, .reg_rdata_out, .reg_rvalid_out, .compare_channel_sel_in, .low_thr_in,
        .flag_clear_in, .adc_sample_in, .adc_channel_out(), .range_out, .core_power_out,
        .keep_alive_out, .result_out, .result_valid_out, .flag_h_out, .flag_l_out(), .alert_out);
    reg_host u_reg_host (.core_clk_in(core_clk_in), .reg_addr_out(reg_addr_in),
        .reg_write_out(reg_write_in), .reg_wdata_out(reg_wdata_in), .reg_read_out(reg_read_in),
        .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));

    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end

    task automatic complete_run();
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check_reset();
        logic [15:0] d;
        `CHK("alert idle", 1'b1, alert_out)
        u_reg_host.rd(REG_HIGH_THRESHOLD, d);
        `CHK("thr reset", {THR_H_EXP_RST, THR_H_MANT_RST}, d)
        u_reg_host.rd(REG_MEAS_CONFIG, d);
        `CHK("cfg reset", 16'h3208, d)
        u_reg_host.wr(8'h0B, 16'h1234);
        u_reg_host.rd(8'h0B, d);
        `CHK("unmapped", 16'h0000, d)
        u_reg_host.wr(REG_HIGH_THRESHOLD, 16'h5A3C);
        u_reg_host.rd(REG_HIGH_THRESHOLD, d);
        `CHK("thr rw", 16'h5A3C, d)
    endtask : check_reset

    task automatic one_shot(input logic qw, input logic [3:0] rng, ct, output int gap);
        logic [15:0] d;
        int n;
        int t;
        n = 0;
        gap = 0;
        u_reg_host.wr(REG_MEAS_CONFIG, {qw, 1'b0, rng, ct, MODE_ONE_SHOT, 4'h8});
        u_reg_host.rd(REG_MEAS_CONFIG, d);
        for (t = 0; t < 300 && n < 4; t++)
        begin
            @(posedge core_clk_in);
            #1;
            if (n == 1)
                gap++;
            if (result_valid_out === 1'b1)
            begin
                `CHK("channel", n[1:0], result_out.channel)
                `CHK("exponent", rng, result_out.exponent)
                `CHK("range pin", rng, range_out)
                n++;
            end
        end
        `CHK("results", 4, n)
        if (n < 4)
            complete_run();
        repeat (4) @(posedge core_clk_in);
        u_reg_host.rd(REG_MEAS_CONFIG, d);
        `CHK("one-shot end", {qw, 1'b0, rng, ct, MODE_POWER_DOWN, 4'h8}, d)
        `CHK("standby", qw, keep_alive_out)
    endtask : one_shot

    task automatic threshold_hold();
        int n;
        int t;
        n = 0;
        compare_channel_sel_in = 2'h1;
        u_reg_host.wr(REG_HIGH_THRESHOLD, 16'h0100);
        u_reg_host.wr(REG_MEAS_CONFIG, 16'h003D);
        for (t = 0; t < 300 && flag_h_out !== 1'b1; t++)
        begin
            @(posedge core_clk_in);
            #1;
            if (result_valid_out === 1'b1 && result_out.channel === 2'h1)
                n++;
        end
        `CHK("flag raised", 1'b1, flag_h_out)
        if (t >= 300)
            complete_run();
        `CHK("faults to flag", 2, n)
        `CHK("alert active", 1'b1, alert_out)
        adc_sample_in = '{1'b0, 12'h050};
        repeat (40) @(posedge core_clk_in);
        #1;
        `CHK("held flag", 1'b1, flag_h_out)
        flag_clear_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        flag_clear_in = 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1;
        `CHK("flag cleared", 1'b0, flag_h_out)
        `CHK("alert released", 1'b0, alert_out)
    endtask : threshold_hold

    initial
    begin
        reset_in = 1'b1;
        flag_clear_in = 1'b0;
        compare_channel_sel_in = 2'h0;
        low_thr_in = 16'h0000;
        adc_sample_in = '{1'b0, 12'h200};
        repeat (4) @(posedge core_clk_in);
        #1;
        reset_in = 1'b0;
        check_reset();
        one_shot(1'b0, 4'h3, 4'h0, g0);
        one_shot(1'b1, 4'h5, 4'h3, g1);
        `CHK("conversion time", 3, g1 - g0)
        threshold_hold();
        complete_run();
    end
endmodule : color_sense_ctrl_bench
